// ==== reset_wake_cfg.svh ====
// Notes on behaviour
// - Reboot input low resets the processor in hardware, no firmware involved.
// - Wired variant: restore input polled; low for six seconds restores defaults then reboots.
// - Wired variant: restore low across a reboot brings the unit up with defaults.
// - Wireless variant: restore held over 6 s then released restores defaults.
// - Wireless: restore low at reset release boots default command line, keeps config.
// - Wake input rising edge leaves sleep when wake-up is enabled.
// - Sleep only entered while wake input is low and configuration allows it.
// - After about 5 s of restore hold, status indicator blinks once a second.
// - Internal 200 ms reset at power-up and after the external reboot input.
`ifndef RESET_WAKE_CFG_SVH
`define RESET_WAKE_CFG_SVH

`define CLK_FREQ_HZ 125000000
`define TICK_PERIOD_US 1000
`define TICK_CYCLES ((`CLK_FREQ_HZ / 1000000) * `TICK_PERIOD_US)
`define TICK_CNT_W 17
`define MS_CNT_W 13
`define RESET_PULSE_MS 200
`define REBOOT_MIN_MS 50
`define RESTORE_HOLD_MS 6000
`define BLINK_START_MS 5000
`define BLINK_HALF_MS 500
`define DEBOUNCE_MS 4
`define DEBOUNCE_CNT_W 3

`endif

// ==== reset_wake_pkg.sv ====
package reset_wake_pkg;

  typedef enum logic [2:0] {
    ST_POWER_UP,
    ST_REBOOT_HELD,
    ST_RESET_PULSE,
    ST_RUN,
    ST_SLEEP
  } seq_state_e;

  typedef struct packed {
    logic sync_first;
    logic sync_second;
    logic level;
    logic [2:0] stable_cnt;
  } debounce_state_s;

  typedef struct packed {
    seq_state_e state;
    logic [16:0] tick_cnt;
    logic tick;
    logic [12:0] phase_ms;
    logic [12:0] hold_ms;
    logic restore_armed;
    logic cli_default;
    logic factory_restore;
    logic cpu_reset;
    logic indicator;
    logic sleeping;
    logic wake_prev;
    logic wake_event;
  } seq_state_s;

  typedef struct packed {
    logic wake_enable;
    logic sleep_allowed;
    logic sleep_request;
    logic wireless_variant;
  } seq_cfg_s;

endpackage : reset_wake_pkg

// ==== input_debounce.sv ====
`timescale 1ns/10ps
`include "reset_wake_cfg.svh"

module input_debounce #(
  parameter logic RESET_LEVEL = 1'b1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Raw pin and millisecond tick
  input wire logic pin_i,
  input wire logic tick_i,
  // Clean level
  output logic level_o
);

  reset_wake_pkg::debounce_state_s state_reg;
  reset_wake_pkg::debounce_state_s state_next;

  always_comb begin
    state_next = state_reg;
    state_next.sync_first = pin_i;
    state_next.sync_second = state_reg.sync_first;
    // Level only moves after a full quiet window
    if (state_reg.sync_second == state_reg.level) begin
      state_next.stable_cnt = 3'h0;
    end else if (tick_i) begin
      if (state_reg.stable_cnt == 3'(`DEBOUNCE_MS - 1)) begin
        state_next.level = state_reg.sync_second;
        state_next.stable_cnt = 3'h0;
      end else begin
        state_next.stable_cnt = state_reg.stable_cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_reg <= '{sync_first: RESET_LEVEL, sync_second: RESET_LEVEL, level: RESET_LEVEL, stable_cnt: 3'h0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign level_o = state_reg.level;

endmodule : input_debounce

// ==== reset_default_wake_control.sv ====
`timescale 1ns/10ps
`include "reset_wake_cfg.svh"

module reset_default_wake_control #(
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  // Clock and power-up reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Board pins
  input wire logic external_reboot_n_i,
  input wire logic restore_default_n_i,
  input wire logic wake_i,
  // Configuration from firmware
  input wire reset_wake_pkg::seq_cfg_s cfg_i,
  // Outputs
  output logic cpu_reset_o,
  output logic factory_restore_o,
  output logic cli_default_boot_o,
  output logic status_indicator_out_o,
  output logic sleep_o,
  output logic wake_event_o
);

  reset_wake_pkg::seq_state_s state_reg;
  reset_wake_pkg::seq_state_s state_next;
  logic reboot_level;
  logic restore_level;
  logic wake_level;

  function automatic logic [12:0] sat_inc(input logic [12:0] value);
    sat_inc = (value == 13'h1FFF) ? value : value + 13'h1;
  endfunction : sat_inc

  input_debounce #(.RESET_LEVEL(1'b1)) reboot_deb (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .pin_i(external_reboot_n_i),
    .tick_i(state_reg.tick),
    .level_o(reboot_level)
  );

  input_debounce #(.RESET_LEVEL(1'b1)) restore_deb (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .pin_i(restore_default_n_i),
    .tick_i(state_reg.tick),
    .level_o(restore_level)
  );

  // Wake idles low so a board that leaves it low does not fake an edge
  input_debounce #(.RESET_LEVEL(1'b0)) wake_deb (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .pin_i(wake_i),
    .tick_i(state_reg.tick),
    .level_o(wake_level)
  );

  always_comb begin
    state_next = state_reg;
    state_next.factory_restore = 1'b0;
    state_next.wake_event = 1'b0;
    state_next.wake_prev = wake_level;

    // Millisecond enable
    if (state_reg.tick_cnt == `TICK_CNT_W'(TICK_CYCLES - 1)) begin
      state_next.tick_cnt = '0;
      state_next.tick = 1'b1;
    end else begin
      state_next.tick_cnt = state_reg.tick_cnt + `TICK_CNT_W'(1);
      state_next.tick = 1'b0;
    end

    unique case (state_reg.state)
      reset_wake_pkg::ST_POWER_UP,
      reset_wake_pkg::ST_RESET_PULSE: begin
        state_next.indicator = 1'b0;
        if (!reboot_level) begin
          state_next.state = reset_wake_pkg::ST_REBOOT_HELD;
        end else if (state_reg.tick) begin
          state_next.phase_ms = sat_inc(state_reg.phase_ms);
          if (state_reg.phase_ms == `MS_CNT_W'(`RESET_PULSE_MS - 1)) begin
            state_next.state = reset_wake_pkg::ST_RUN;
            state_next.cpu_reset = 1'b0;
            state_next.indicator = 1'b1;
            state_next.hold_ms = '0;
            state_next.cli_default = 1'b0;
            state_next.restore_armed = restore_level;
            if (!restore_level) begin
              if (cfg_i.wireless_variant) begin
                state_next.cli_default = 1'b1;
              end else begin
                state_next.factory_restore = 1'b1;
              end
            end
          end
        end
      end

      reset_wake_pkg::ST_REBOOT_HELD: begin
        // Board keeps the pin low long enough; the pulse starts on release
        state_next.cpu_reset = 1'b1;
        state_next.indicator = 1'b0;
        state_next.sleeping = 1'b0;
        state_next.phase_ms = '0;
        if (reboot_level) begin
          state_next.state = reset_wake_pkg::ST_RESET_PULSE;
        end
      end

      reset_wake_pkg::ST_RUN: begin
        if (!reboot_level) begin
          state_next.state = reset_wake_pkg::ST_REBOOT_HELD;
        end else if (restore_level) begin
          state_next.restore_armed = 1'b1;
          state_next.indicator = 1'b1;
          state_next.hold_ms = '0;
          // Released after a long hold
          if (cfg_i.wireless_variant && state_reg.hold_ms > `MS_CNT_W'(`RESTORE_HOLD_MS)) begin
            state_next.factory_restore = 1'b1;
            state_next.state = reset_wake_pkg::ST_RESET_PULSE;
            state_next.cpu_reset = 1'b1;
            state_next.phase_ms = '0;
          end
        end else if (state_reg.restore_armed && state_reg.tick) begin
          // Polled hold timer, ignored until seen high after boot
          state_next.hold_ms = sat_inc(state_reg.hold_ms);
          if (state_reg.hold_ms >= `MS_CNT_W'(`BLINK_START_MS)) begin
            if ((state_reg.hold_ms - `MS_CNT_W'(`BLINK_START_MS)) % `MS_CNT_W'(`BLINK_HALF_MS) == '0) begin
              state_next.indicator = ~state_reg.indicator;
            end
          end
          if (!cfg_i.wireless_variant && state_reg.hold_ms == `MS_CNT_W'(`RESTORE_HOLD_MS - 1)) begin
            state_next.factory_restore = 1'b1;
            state_next.state = reset_wake_pkg::ST_RESET_PULSE;
            state_next.cpu_reset = 1'b1;
            state_next.phase_ms = '0;
          end
        end
        // Sleep only while wake is low, allowed and no restore hold running
        if (cfg_i.sleep_request && cfg_i.sleep_allowed && !wake_level && reboot_level && restore_level
            && state_reg.hold_ms == '0) begin
          state_next.state = reset_wake_pkg::ST_SLEEP;
          state_next.sleeping = 1'b1;
        end
      end

      reset_wake_pkg::ST_SLEEP: begin
        if (!reboot_level) begin
          state_next.state = reset_wake_pkg::ST_REBOOT_HELD;
        end else if (wake_level && !state_reg.wake_prev && cfg_i.wake_enable) begin
          state_next.state = reset_wake_pkg::ST_RUN;
          state_next.sleeping = 1'b0;
          state_next.wake_event = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_reg <= '{state: reset_wake_pkg::ST_POWER_UP, tick_cnt: '0, tick: 1'b0, phase_ms: '0, hold_ms: '0,
                     restore_armed: 1'b0, cli_default: 1'b0, factory_restore: 1'b0, cpu_reset: 1'b1,
                     indicator: 1'b0, sleeping: 1'b0, wake_prev: 1'b0, wake_event: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign cpu_reset_o = state_reg.cpu_reset;
  assign factory_restore_o = state_reg.factory_restore;
  assign cli_default_boot_o = state_reg.cli_default;
  assign status_indicator_out_o = state_reg.indicator;
  assign sleep_o = state_reg.sleeping;
  assign wake_event_o = state_reg.wake_event;

endmodule : reset_default_wake_control

// ==== reset_wake_sva.sv ====
`timescale 1ns/10ps
module reset_wake_sva #(
  parameter int TICK_CYCLES = 125000
) (
  // Clock, reset and pins
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic external_reboot_n_i,
  input wire logic restore_default_n_i,
  input wire logic wake_i,
  input wire reset_wake_pkg::seq_cfg_s cfg_i,
  // Outputs
  input wire logic cpu_reset_o,
  input wire logic factory_restore_o,
  input wire logic cli_default_boot_o,
  input wire logic status_indicator_out_o,
  input wire logic sleep_o,
  input wire logic wake_event_o
);
  int low_cnt;
  int rst_cnt;
  // Saturate so a long hold cannot wrap
  always_ff @(posedge clk_i) begin
    if (reset_i || external_reboot_n_i) low_cnt <= 0;
    else if (low_cnt < 8 * TICK_CYCLES) low_cnt <= low_cnt + 1;
    if (reset_i || !cpu_reset_o || !external_reboot_n_i) rst_cnt <= 0;
    else rst_cnt <= rst_cnt + 1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence s_wake_exit;
    sleep_o ##1 wake_event_o;
  endsequence
  sequence s_sleep_entry;
    !sleep_o ##1 sleep_o;
  endsequence
  AST_POWERUP: assert property ($fell(reset_i) |-> cpu_reset_o [*8])
    else $error("reset pulse missing after power-up");
  AST_REBOOT: assert property (low_cnt >= 6 * TICK_CYCLES + 4 |-> cpu_reset_o)
    else $error("held reboot pin gave no cpu reset");
  AST_RESET_MIN: assert property ($fell(cpu_reset_o) |-> rst_cnt >= 199 * TICK_CYCLES)
    else $error("cpu reset pulse too short");
  AST_RESET_MAX: assert property (rst_cnt <= 206 * TICK_CYCLES)
    else $error("cpu reset pulse too long");
  AST_FR_ONE: assert property (factory_restore_o |=> !factory_restore_o)
    else $error("factory restore wider than one cycle");
  AST_FR_RESET: assert property (factory_restore_o |-> cpu_reset_o || $past(cpu_reset_o))
    else $error("factory restore without reboot");
  AST_WAKE: assert property (s_wake_exit |-> !sleep_o ##1 !wake_event_o)
    else $error("wake event did not leave sleep");
  AST_WAKE_EN: assert property (wake_event_o |-> $past(cfg_i.wake_enable))
    else $error("wake while wake-up disabled");
  AST_SLEEP: assert property (s_sleep_entry |-> $past(cfg_i.sleep_request && cfg_i.sleep_allowed))
    else $error("sleep entered without permission");
  AST_SLEEP_RESET: assert property (cpu_reset_o |-> !sleep_o)
    else $error("asleep during cpu reset");
  AST_CLI: assert property ($rose(cli_default_boot_o) |-> $fell(cpu_reset_o))
    else $error("command-line boot away from reset end");
endmodule : reset_wake_sva
bind reset_default_wake_control reset_wake_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (.*);

// ==== host_board_model.sv ====
`timescale 1ns/10ps
module host_board_model #(
  parameter int TC = 10
) (
  // Clock
  input wire logic clk_i,
  // Pins toward the unit; reboot and restore pulled up when released, wake idles low
  output logic external_reboot_n_o,
  output logic restore_default_n_o,
  output logic wake_o
);
  initial begin
    external_reboot_n_o = 1'b1;
    restore_default_n_o = 1'b1;
    wake_o = 1'b0;
  end
  // Short holds only when a scenario wants a glitch
  task automatic reboot_pulse(input int ms);
    @(posedge clk_i);
    external_reboot_n_o <= 1'b0;
    repeat (ms * TC) @(posedge clk_i);
    external_reboot_n_o <= 1'b1;
  endtask : reboot_pulse
  task automatic restore_level(input logic v);
    @(posedge clk_i);
    restore_default_n_o <= v;
  endtask : restore_level
  task automatic wake_level(input logic v);
    @(posedge clk_i);
    wake_o <= v;
  endtask : wake_level
endmodule : host_board_model

// ==== reset_default_wake_control_tb.sv ====
`timescale 1ns/10ps
module reset_default_wake_control_tb;
  localparam int TC = 5;
  logic clk_i;
  logic reset_i;
  logic rb_n, rs_n, wk;
  reset_wake_pkg::seq_cfg_s cfg_i;
  logic cpu_rst, fr, cli, ind, slp, wev;
  int num_errors = 0;
  int n_tests = 0;
  int n;
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
  host_board_model #(.TC(TC)) u_board (.clk_i(clk_i), .external_reboot_n_o(rb_n), .restore_default_n_o(rs_n),
    .wake_o(wk));
  reset_default_wake_control #(.TICK_CYCLES(TC)) DUT (.clk_i(clk_i), .reset_i(reset_i), .external_reboot_n_i(rb_n),
    .restore_default_n_i(rs_n), .wake_i(wk), .cfg_i(cfg_i), .cpu_reset_o(cpu_rst), .factory_restore_o(fr),
    .cli_default_boot_o(cli), .status_indicator_out_o(ind), .sleep_o(slp), .wake_event_o(wev));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  task automatic wait_run();
    n = 0;
    while (cpu_rst !== 1'b0 && n < 300 * TC) begin
      @(negedge clk_i);
      n++;
    end
  endtask : wait_run
  task automatic t_powerup();
    `CHK("cpu_reset", 1'b1, cpu_rst)
    wait_run();
    `CHK("pulse_len", 1'b1, n >= 198 * TC && n <= 201 * TC)
    `CHK("indicator", 1'b1, ind)
    $display("t_powerup done");
  endtask : t_powerup
  task automatic t_reboot();
    u_board.reboot_pulse(2);
    repeat (10 * TC) @(negedge clk_i);
    `CHK("glitch", 1'b0, cpu_rst)
    u_board.reboot_pulse(50);
    `CHK("cpu_reset", 1'b1, cpu_rst)
    wait_run();
    `CHK("pulse_len", 1'b1, n >= 199 * TC && n <= 207 * TC)
    $display("t_reboot done");
  endtask : t_reboot
  task automatic t_sleep();
    @(posedge clk_i);
    cfg_i <= 4'h2;
    repeat (8 * TC) @(negedge clk_i);
    `CHK("sleep_blocked", 1'b0, slp)
    @(posedge clk_i);
    cfg_i <= 4'h6;
    repeat (3) @(negedge clk_i);
    `CHK("sleep", 1'b1, slp)
    u_board.wake_level(1'b1);
    repeat (8 * TC) @(negedge clk_i);
    `CHK("wake_disabled", 1'b1, slp)
    u_board.wake_level(1'b0);
    repeat (8 * TC) @(negedge clk_i);
    @(posedge clk_i);
    cfg_i <= 4'hE;
    u_board.wake_level(1'b1);
    n = 0;
    while (wev !== 1'b1 && n < 10 * TC) begin
      @(negedge clk_i);
      n++;
    end
    `CHK("wake_event", 1'b1, wev)
    `CHK("awake", 1'b0, slp)
    @(posedge clk_i);
    cfg_i <= 4'h1;
    u_board.wake_level(1'b0);
    $display("t_sleep done");
  endtask : t_sleep
  task automatic t_cli();
    u_board.restore_level(1'b0);
    u_board.reboot_pulse(50);
    wait_run();
    @(negedge clk_i);
    `CHK("cli_boot", 1'b1, cli)
    `CHK("no_restore", 1'b0, fr)
    u_board.restore_level(1'b1);
    repeat (10 * TC) @(negedge clk_i);
    $display("t_cli done");
  endtask : t_cli
  task automatic t_wired_boot();
    @(posedge clk_i);
    cfg_i <= 4'h0;
    u_board.restore_level(1'b0);
    u_board.reboot_pulse(50);
    wait_run();
    `CHK("boot_restore", 1'b1, fr)
    `CHK("no_cli", 1'b0, cli)
    u_board.restore_level(1'b1);
    repeat (10 * TC) @(negedge clk_i);
    $display("t_wired_boot done");
  endtask : t_wired_boot
  task automatic t_wireless();
    logic li;
    int nt, nf;
    nt = 0;
    nf = 0;
    @(posedge clk_i);
    cfg_i <= 4'h1;
    u_board.restore_level(1'b0);
    li = ind;
    for (int i = 1; i < 6100 * TC; i++) begin
      @(negedge clk_i);
      if (ind !== li) nt++;
      li = ind;
      if (fr === 1'b1) nf++;
    end
    `CHK("w_blinks", 3, nt)
    `CHK("w_early", 0, nf)
    u_board.restore_level(1'b1);
    n = 0;
    while (fr !== 1'b1 && n < 10 * TC) begin
      @(negedge clk_i);
      n++;
    end
    `CHK("w_restore", 1'b1, fr)
    `CHK("w_reboot", 1'b1, cpu_rst)
    wait_run();
    `CHK("w_run", 1'b0, cpu_rst)
    $display("t_wireless done");
  endtask : t_wireless
  task automatic t_restore();
    logic li;
    int nt, tf, nf;
    nt = 0;
    tf = 0;
    nf = 0;
    @(posedge clk_i);
    cfg_i <= 4'h0;
    u_board.restore_level(1'b0);
    li = ind;
    for (int i = 1; i < 6100 * TC; i++) begin
      @(negedge clk_i);
      if (nf == 0 && ind !== li) nt++;
      li = ind;
      if (fr === 1'b1) begin
        nf++;
        tf = i;
      end
    end
    `CHK("blinks", 2, nt)
    `CHK("restores", 1, nf)
    `CHK("hold_len", 1'b1, tf >= 6002 * TC && tf <= 6007 * TC)
    `CHK("reboot", 1'b1, cpu_rst)
    u_board.restore_level(1'b1);
    wait_run();
    `CHK("run", 1'b0, cpu_rst)
    $display("t_restore done");
  endtask : t_restore
  initial begin
    reset_i = 1'b1;
    cfg_i = 4'h0;
    repeat (12) @(posedge clk_i);
    reset_i <= 1'b0;
    @(negedge clk_i);
    t_powerup();
    t_reboot();
    t_sleep();
    t_cli();
    t_wired_boot();
    t_restore();
    t_wireless();
    print_verdict();
  end
  // Tests take about 70000 cycles
  initial begin
    #(110000 * 8);
    num_errors++;
    print_verdict();
  end
endmodule : reset_default_wake_control_tb
